// *** shared/frame_sync_params.svh ***
// Constants for the external frame sync trigger block
`ifndef FRAME_SYNC_PARAMS_SVH
`define FRAME_SYNC_PARAMS_SVH
`define CLK_PERIOD_NS 10
`define TRIG_LATENCY_NS 160
// The two synchroniser stages that detect the edge are part of the latency; the load edge starts the count
`define PIPE_CYCLES 2
`define TRIG_LATENCY_CYC (`TRIG_LATENCY_NS / `CLK_PERIOD_NS)
`define FIXED_WAIT_CYC (`TRIG_LATENCY_CYC - `PIPE_CYCLES)
`define DELAY_W 16
`endif

// *** shared/frame_sync_pkg.sv ***
// Types for the external frame sync trigger block
package frame_sync_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_FIRE = 3'b100
    } trig_state_e;

    typedef struct packed {
        logic arm;
        logic [15:0] extra_delay;
    } trig_cfg_s;

    typedef struct packed {
        logic frame_start;
        logic armed;
        logic busy;
    } trig_status_s;

    typedef struct packed {
        logic sync_1;
        logic sync_2;
        logic sync_prev;
        logic armed;
        trig_state_e state;
        logic [16:0] count;
        logic frame_start;
    } trig_state_s;
endpackage

// *** src/frame_sync_trigger.sv ***
// External frame sync trigger: synchroniser, edge detect, latency and programmable delay
`timescale 1ns/1ps
`default_nettype none
`include "frame_sync_params.svh"

// Functional notes
// - Each valid host sync pulse starts exactly one radar frame.
// - Pulses are ignored until software arms hardware triggering.
// - Sync rising edge to frame start is 160 ns with zero extra delay.
// - A programmable extra delay in cycles adds onto the fixed latency.
module frame_sync_trigger #(
    parameter int DELAY_W = `DELAY_W
) (
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire logic SYNC_IN,
    input wire frame_sync_pkg::trig_cfg_s CFG,
    output frame_sync_pkg::trig_status_s STATUS
);
    import frame_sync_pkg::*;

    localparam logic [16:0] FIXED_WAIT = 17'(`FIXED_WAIT_CYC);
    // The start flag is visible one sampling edge after the countdown ends
    localparam int LAT_CYC = `FIXED_WAIT_CYC + 1;

    trig_state_s s_reg;
    trig_state_s s_next;
    logic rise;

    // **********************************
    // Next state
    // **********************************
    // Timeline with no extra delay: the first edge that samples the pin high is E,
    // the edge is seen in the cycle after E+1, the countdown is loaded at E+2
    // and the start flag is registered at E+16, which gives the fixed latency.
    // The extra delay only stretches the countdown, so the pipeline part never
    // changes with the programmed value.
    always_comb begin
        s_next = s_reg;
        s_next.sync_1 = SYNC_IN;
        s_next.sync_2 = s_reg.sync_1;
        s_next.sync_prev = s_reg.sync_2;
        s_next.armed = CFG.arm;
        s_next.frame_start = 1'b0;
        rise = s_reg.sync_2 & ~s_reg.sync_prev;
        case (s_reg.state)
            ST_IDLE: begin
                // A pulse arriving while a trigger is pending is dropped; the host spacing makes this rare
                if (rise && s_reg.armed) begin
                    s_next.state = ST_WAIT;
                    s_next.count = FIXED_WAIT + 17'(CFG.extra_delay);
                end
            end
            ST_WAIT: begin
                // Firing on the last count rather than on zero saves a cycle that the
                // fixed latency has no room for
                if (s_reg.count <= 17'h00001) begin
                    s_next.state = ST_FIRE;
                    s_next.frame_start = 1'b1;
                end else begin
                    s_next.count = s_reg.count - 17'h00001;
                end
            end
            ST_FIRE: begin
                s_next.state = ST_IDLE;
                s_next.count = 17'h00000;
            end
            default: begin
                s_next.state = ST_IDLE;
            end
        endcase
    end

    // **********************************
    // State register
    // **********************************
    // Reset drops any pending trigger; the host has to pulse again
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            s_reg <= '{
                sync_1: 1'b0,
                sync_2: 1'b0,
                sync_prev: 1'b0,
                armed: 1'b0,
                state: ST_IDLE,
                count: 17'h00000,
                frame_start: 1'b0
            };
        end else begin
            s_reg <= s_next;
        end
    end

    // **********************************
    // Status outputs
    // **********************************
    assign STATUS.frame_start = s_reg.frame_start;
    assign STATUS.armed = s_reg.armed;
    assign STATUS.busy = (s_reg.state != ST_IDLE);

    // **********************************
    // Assertions
    // **********************************
    sequence edge_armed_s;
        s_reg.sync_2 && !s_reg.sync_prev && s_reg.armed && s_reg.state == ST_IDLE;
    endsequence

    sequence zero_delay_s;
        edge_armed_s ##0 (CFG.extra_delay == 16'h0000);
    endsequence

    property latency_p;
        @(posedge CLK_SYS) disable iff (!RESETN)
        zero_delay_s |-> ##LAT_CYC s_reg.frame_start;
    endproperty

    fixed_latency_a: assert property (latency_p)
        else $error("Frame start not at fixed latency");

    unarmed_quiet_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        (s_reg.state == ST_IDLE && !s_reg.armed) |=> s_reg.state == ST_IDLE)
        else $error("Trigger left idle while unarmed");

    start_one_cycle_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        s_reg.frame_start |=> !s_reg.frame_start)
        else $error("Frame start longer than one cycle");

    edge_starts_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        edge_armed_s |=> s_reg.state == ST_WAIT)
        else $error("Armed edge did not start delay");

    delay_load_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        edge_armed_s |=> s_reg.count == FIXED_WAIT + 17'($past(CFG.extra_delay)))
        else $error("Delay count wrong");

    fire_from_wait_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        $rose(s_reg.frame_start) |-> $past(s_reg.state) == ST_WAIT)
        else $error("Frame start without pending trigger");

    level_no_retrigger_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        (s_reg.state == ST_IDLE && s_reg.sync_2 && s_reg.sync_prev) |=> s_reg.state == ST_IDLE)
        else $error("Held level retriggered");

    // **********************************
    // Pending trigger bookkeeping
    // **********************************
    sequence in_wait_s;
        s_reg.state == ST_WAIT;
    endsequence

    sequence in_fire_s;
        s_reg.state == ST_FIRE;
    endsequence

    sequence last_tick_s;
        in_wait_s ##0 (s_reg.count <= 17'h00001);
    endsequence

    armed_copy_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        1'b1 |=> s_reg.armed == $past(CFG.arm))
        else $error("Armed flag does not follow arm input");

    wait_nonzero_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        in_wait_s |-> s_reg.count != 17'h00000)
        else $error("Countdown empty while waiting");

    countdown_step_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        (in_wait_s ##0 (s_reg.count > 17'h00001)) |=> s_reg.count == $past(s_reg.count) - 17'h00001)
        else $error("Countdown did not step by one");

    last_tick_fires_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        last_tick_s |=> in_fire_s ##0 s_reg.frame_start)
        else $error("Last count did not fire");

    fire_to_idle_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        in_fire_s |=> s_reg.state == ST_IDLE && !s_reg.frame_start)
        else $error("Fire state did not return to idle");

    start_only_fire_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        s_reg.frame_start |-> in_fire_s)
        else $error("Frame start outside fire state");

    busy_pending_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        in_wait_s |-> STATUS.busy)
        else $error("Busy low while trigger pending");

    idle_count_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        s_reg.state == ST_IDLE |-> s_reg.count == 17'h00000)
        else $error("Stale count while idle");

    // **********************************
    // Synchroniser chain
    // **********************************
    sync_chain_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        1'b1 |=> s_reg.sync_2 == $past(s_reg.sync_1))
        else $error("Second stage does not follow first");

    prev_chain_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        1'b1 |=> s_reg.sync_prev == $past(s_reg.sync_2))
        else $error("Edge register does not follow second stage");
endmodule // frame_sync_trigger
`default_nettype wire

// *** tb/sync_host_model.sv ***
// Host model that pulses the frame sync line
`timescale 1ns/1ps
`default_nettype none
module sync_host_model (
    input wire logic clk,
    output logic sync
);
    initial sync = 1'b0;
    // Width 3 to 399 cycles keeps 30 ns to under 4000 ns
    task automatic pulse(input int cycles);
        @(negedge clk) sync = 1'b1;
        repeat (cycles) @(negedge clk);
        sync = 1'b0;
        // Idle gap outlasts a whole pending trigger
        repeat (40) @(negedge clk);
    endtask
endmodule // sync_host_model
`default_nettype wire

// *** tb/frame_sync_trigger_tb.sv ***
// Self-checking bench for the frame sync trigger
`timescale 1ns/1ps
`default_nettype none
module frame_sync_trigger_tb;
    import frame_sync_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    wire logic sync_in;
    trig_cfg_s cfg = '0;
    trig_status_s st;
    int errors = 0;
    int tests_run = 0;
    frame_sync_trigger frame_sync_trigger_i (.CLK_SYS(clk), .RESETN(resetn), .SYNC_IN(sync_in), .CFG(cfg),
        .STATUS(st));
    sync_host_model sync_host_model_i (.clk(clk), .sync(sync_in));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic set_cfg(input logic arm, input logic [15:0] dly);
        @(negedge clk) cfg = '{arm: arm, extra_delay: dly};
        repeat (2) @(negedge clk);
    endtask
    // Edge index 0 samples the rise; returns first start index and start count
    task automatic run(input int w, output logic [15:0] f, output logic [15:0] n);
        f = 16'h0000;
        n = 16'h0000;
        fork
            sync_host_model_i.pulse(w);
        join_none
        @(negedge clk);
        for (int i = 0; i < w + 60; i++) begin
            @(posedge clk);
            #1;
            if (st.frame_start === 1'b1) begin
                if (n == 16'h0000) f = 16'(i);
                n++;
            end
        end
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_unarmed;
        logic [15:0] f, n;
        set_cfg(1'b0, 16'h0000);
        chk(16'(st.armed), 16'h0000);
        run(3, f, n);
        chk(n, 16'h0000);
        $display("unarmed done");
    endtask
    task automatic t_latency;
        logic [15:0] f, n;
        set_cfg(1'b1, 16'h0000);
        run(3, f, n);
        chk(f, 16'h0010);
        chk(n, 16'h0001);
        $display("latency done");
    endtask
    task automatic t_delay;
        logic [15:0] f, n;
        set_cfg(1'b1, 16'h0005);
        run(300, f, n);
        chk(f, 16'h0015);
        chk(n, 16'h0001);
        $display("delay done");
    endtask
    // Busy rises when the countdown is loaded and falls after the fire cycle
    task automatic t_busy;
        logic [15:0] f, n;
        f = 16'h0000;
        n = 16'h0000;
        set_cfg(1'b1, 16'h0000);
        chk(16'(st.armed), 16'h0001);
        fork
            sync_host_model_i.pulse(3);
        join_none
        @(negedge clk);
        for (int i = 0; i < 60; i++) begin
            @(posedge clk);
            #1;
            if (st.busy === 1'b1) begin
                if (n == 16'h0000) f = 16'(i);
                n++;
            end
        end
        chk(f, 16'h0002);
        chk(n, 16'h000f);
        $display("busy done");
    endtask
    // Reset in mid countdown drops the pending trigger
    task automatic t_reset;
        logic [15:0] f, n;
        set_cfg(1'b1, 16'h0000);
        fork
            sync_host_model_i.pulse(3);
        join_none
        repeat (6) @(negedge clk);
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        chk(16'(st), 16'h0000);
        resetn = 1'b1;
        f = 16'h0000;
        n = 16'h0000;
        for (int i = 0; i < 60; i++) begin
            @(posedge clk);
            #1;
            if (st.frame_start === 1'b1) n++;
        end
        chk(n, 16'h0000);
        $display("reset done");
    endtask
    task automatic wrap_up;
        $display("tests_run %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clk);
        resetn = 1'b1;
        t_unarmed();
        t_latency();
        t_delay();
        t_busy();
        t_reset();
        wrap_up();
    end
    initial begin
        #20us;
        errors++;
        wrap_up();
    end
endmodule // frame_sync_trigger_tb
`default_nettype wire
